// file: inc/tpsp_pkg.sv
// Package for the primary/secondary period timer block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package tpsp_pkg;
    // Printed offsets are not multiples of four: these are register indices
    localparam logic [11:0] TPSP_IDX_SECONDARY = 12'h10D;
    localparam logic [11:0] TPSP_IDX_PRIMARY = 12'h10E;
    localparam logic [11:0] TPSP_IDX_CONTROL = 12'h10F;
    localparam logic [11:0] TPSP_IDX_MODE = 12'h110;
    localparam logic [7:0] TPSP_PRIMARY_RESET = 8'hFF;
    localparam logic [7:0] TPSP_SECONDARY_RESET = 8'hFF;
    localparam logic [7:0] TPSP_STOP_PRESET = 8'hFF;
    localparam int TPSP_CTRL_START_BIT = 0;
    localparam int TPSP_CTRL_STOP_BIT = 2;
    localparam logic [1:0] TPSP_MODE_RESET = 2'h0;
    localparam logic [7:0] TPSP_PRESCALE_RESET = 8'h00;
    typedef enum logic [1:0] {
        TPSP_MODE_TIMER = 2'b00,
        TPSP_MODE_WAVE = 2'b01,
        TPSP_MODE_ONESHOT = 2'b10,
        TPSP_MODE_WAIT = 2'b11
    } tpsp_mode_t;
    function automatic logic [13:0] tpsp_byte_addr(input logic [11:0] idx);
        return {idx, 2'b00};
    endfunction
endpackage

// file: verilog/tpsp_prescaler.sv
// Prescaler that pulses once every (divide+1) system clocks while running.
// Assumes divide is steady while running; changes take effect at next wrap.
`timescale 1ns/100ps
module tpsp_prescaler import tpsp_pkg::*; #(
    parameter int WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [WIDTH-1:0] divide,
    output logic underflow
);
    logic [WIDTH-1:0] count_reg;
    if (WIDTH < 1) begin
        $error("prescaler width must be positive");
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
            underflow <= 1'b0;
        end else if (!run) begin
            count_reg <= divide;
            underflow <= 1'b0;
        end else if (count_reg == '0) begin
            count_reg <= divide;
            underflow <= 1'b1;
        end else begin
            count_reg <= count_reg - 1'b1;
            underflow <= 1'b0;
        end
    end
endmodule

// file: verilog/tpsp_timer.sv
// Top of the primary/secondary period timer with its APB register slave.
// Assumes a single APB master on pclk; zero wait-state answers.
// Notes on behaviour
// - Primary is 8-bit full range, counts underflows
// - Wait one-shot counts pulse width underflows; here wait mode alternates primary, secondary like waveform mode
// - Two-value modes reload primary, secondary alternately
// - Primary read returns live counter value
// - Forced stop write presets secondary to FFh
// - Counter decrements, reloads on underflow
// - Secondary counts in waveform, unused in timer
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
module tpsp_timer import tpsp_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic underflow_pulse,
    output logic wave_out,
    output logic running
);
    logic [7:0] primary_reload_reg;
    logic [7:0] secondary_pend_reg;
    logic [7:0] secondary_reg;
    logic [7:0] counter_reg;
    logic [7:0] prescale_reg;
    logic secondary_phase_reg;
    logic start_reg;
    logic armed_reg;
    tpsp_mode_t mode_reg;
    logic pre_uf;
    logic setup;
    logic wr_sec;
    logic wr_pri;
    logic wr_ctl;
    logic wr_mode;
    logic hit;
    logic two_value;
    logic cnt_zero;
    logic [7:0] reload_next;
    logic stop_req;
    logic start_req;
    logic reload_now;

    // Shared decode, so the error flag and the writes agree on the map
    function automatic logic is_mapped(input logic [13:0] addr);
        return addr == tpsp_byte_addr(TPSP_IDX_SECONDARY)
            || addr == tpsp_byte_addr(TPSP_IDX_PRIMARY)
            || addr == tpsp_byte_addr(TPSP_IDX_CONTROL)
            || addr == tpsp_byte_addr(TPSP_IDX_MODE);
    endfunction

    // Writes act in the access phase, the one edge where pready is high
    function automatic logic bus_write(input logic sel, input logic en, input logic wr,
        input logic [13:0] addr, input logic [11:0] idx);
        return sel && en && wr && addr == tpsp_byte_addr(idx);
    endfunction

    // Control bits must fall inside the data word and must differ
    if (TPSP_CTRL_START_BIT == TPSP_CTRL_STOP_BIT || TPSP_CTRL_START_BIT > 31
        || TPSP_CTRL_STOP_BIT > 31) begin
        $error("control bit positions are unusable");
    end

    // Every register needs its own word, or one decode would shadow another
    if (TPSP_IDX_SECONDARY == TPSP_IDX_PRIMARY || TPSP_IDX_PRIMARY == TPSP_IDX_CONTROL
        || TPSP_IDX_CONTROL == TPSP_IDX_MODE || TPSP_IDX_SECONDARY == TPSP_IDX_MODE) begin
        $error("register indices overlap");
    end

    assign setup = psel && !penable;
    assign hit = is_mapped(paddr);
    assign wr_sec = bus_write(psel, penable, pwrite, paddr, TPSP_IDX_SECONDARY);
    assign wr_pri = bus_write(psel, penable, pwrite, paddr, TPSP_IDX_PRIMARY);
    assign wr_ctl = bus_write(psel, penable, pwrite, paddr, TPSP_IDX_CONTROL);
    assign wr_mode = bus_write(psel, penable, pwrite, paddr, TPSP_IDX_MODE);
    assign stop_req = wr_ctl && pwdata[TPSP_CTRL_STOP_BIT];
    assign reload_now = start_reg && pre_uf && cnt_zero;
    // Stop in the same write as start wins, so a combined write leaves it halted
    assign start_req = pwdata[TPSP_CTRL_START_BIT] && !pwdata[TPSP_CTRL_STOP_BIT];
    assign two_value = mode_reg != TPSP_MODE_TIMER;
    assign cnt_zero = counter_reg == 8'h00;

    tpsp_prescaler #(
        .WIDTH(8)
    ) u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .run(start_reg),
        .divide(prescale_reg),
        .underflow(pre_uf)
    );

    // Next reload: alternate in two-value modes, primary only in timer mode
    always_comb begin
        reload_next = primary_reload_reg;
        if (two_value && !secondary_phase_reg) begin
            reload_next = secondary_reg;
        end
    end

    // Run state; a one-shot drops it after its secondary width
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_reg <= 1'b0;
        end else if (wr_ctl) begin
            start_reg <= start_req;
        end else if (reload_now && mode_reg == TPSP_MODE_ONESHOT
                     && secondary_phase_reg) begin
            start_reg <= 1'b0;
        end
    end

    // While running, a divide change only takes effect at the prescaler's next wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= tpsp_mode_t'(TPSP_MODE_RESET);
            prescale_reg <= TPSP_PRESCALE_RESET;
        end else if (wr_mode) begin
            mode_reg <= tpsp_mode_t'(pwdata[1:0]);
            prescale_reg <= pwdata[15:8];
        end
    end

    // Secondary is held pending until the primary write that follows it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secondary_pend_reg <= TPSP_SECONDARY_RESET;
            secondary_reg <= TPSP_SECONDARY_RESET;
            armed_reg <= 1'b0;
        end else if (wr_ctl && pwdata[TPSP_CTRL_STOP_BIT]) begin
            secondary_pend_reg <= TPSP_STOP_PRESET;
            secondary_reg <= TPSP_STOP_PRESET;
            armed_reg <= 1'b0;
        end else if (wr_sec) begin
            secondary_pend_reg <= pwdata[7:0];
            armed_reg <= 1'b1;
        end else if (wr_pri && armed_reg) begin
            secondary_reg <= secondary_pend_reg;
            armed_reg <= 1'b0;
        end
    end

    // Down-counter; primary writes land in reload and, when stopped, the counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_reload_reg <= TPSP_PRIMARY_RESET;
            counter_reg <= TPSP_PRIMARY_RESET;
            secondary_phase_reg <= 1'b0;
        end else begin
            if (wr_pri) begin
                primary_reload_reg <= pwdata[7:0];
            end
            if (wr_pri && !start_reg) begin
                counter_reg <= pwdata[7:0];
                secondary_phase_reg <= 1'b0;
            end else if (wr_ctl && pwdata[TPSP_CTRL_STOP_BIT]) begin
                counter_reg <= primary_reload_reg;
                secondary_phase_reg <= 1'b0;
            end else if (start_reg && pre_uf) begin
                if (cnt_zero) begin
                    counter_reg <= reload_next;
                    secondary_phase_reg <= two_value && !secondary_phase_reg;
                end else begin
                    counter_reg <= counter_reg - 8'h01;
                end
            end
        end
    end

    // One pulse per reload; a stop write in the same cycle suppresses it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            underflow_pulse <= 1'b0;
        end else begin
            underflow_pulse <= reload_now && !stop_req;
        end
    end

    // APB handshake: no wait states, unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !hit;
        end
    end

    // Status pins lag the internal state by one clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_out <= 1'b0;
            running <= 1'b0;
        end else begin
            wave_out <= two_value && start_reg && secondary_phase_reg;
            running <= start_reg;
        end
    end

    // Read data stands with pready only, so the bus sees zero between reads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= 32'h0000_0000;
            if (setup && !pwrite) begin
                unique case (paddr)
                    tpsp_byte_addr(TPSP_IDX_PRIMARY): prdata <= {24'h000000, counter_reg};
                    tpsp_byte_addr(TPSP_IDX_CONTROL): prdata <= {31'h00000000, start_reg};
                    tpsp_byte_addr(TPSP_IDX_MODE): prdata <= {16'h0000, prescale_reg,
                                                              6'h00, mode_reg};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// file: test/tpsp_timer_monitor.sv
// Port checker for the period timer.
// Assumes it is bound to tpsp_timer and sees only its ports.
`timescale 1ns/100ps
module tpsp_timer_monitor import tpsp_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic underflow_pulse,
    input wire logic wave_out,
    input wire logic running
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_rdata_byte_only: assert property (pready && paddr != {TPSP_IDX_MODE, 2'b00}
        |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_wave_needs_run: assert property (wave_out |-> running)
        else $error("wave high while stopped");
    a_pulse_needs_run: assert property (underflow_pulse |-> $past(running))
        else $error("underflow while stopped");
    a_stop_halts: assert property (pready && pwrite && paddr == {TPSP_IDX_CONTROL, 2'b00}
        && pwdata[TPSP_CTRL_STOP_BIT] |-> ##2 !running [*2])
        else $error("forced stop did not halt");
endmodule

// file: test/tpsp_timer_test.sv
// Self-checking bench for the period timer over APB.
// Assumes zero wait-state answers; the watchdog ends any hang.
`timescale 1ns/100ps
module tpsp_timer_test;
    import tpsp_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [13:0] paddr = 14'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, underflow_pulse, wave_out, running, err;
    int fail_count = 0, tests_run = 0, n, d, s, p, seed = 32'hA137009E;
    localparam logic [13:0] SEC = {TPSP_IDX_SECONDARY, 2'b00}, PRI = {TPSP_IDX_PRIMARY, 2'b00};
    localparam logic [13:0] CTL = {TPSP_IDX_CONTROL, 2'b00}, MDE = {TPSP_IDX_MODE, 2'b00};
    tpsp_timer tpsp_timer_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .underflow_pulse, .wave_out, .running);
    always #10 pclk = ~pclk;
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task complete_run;
        if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Holds the request until pready is seen high at a rising edge
    task apb(input logic w, input logic [13:0] a, input logic [31:0] v);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= v; penable <= 0;
        @(posedge pclk) penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    function automatic int span(input int dv, input int v);
        return (dv + 1) * (v + 1);
    endfunction
    task hi_len;
        n = 0;
        while (wave_out !== 1'b1) @(posedge pclk);
        while (wave_out === 1'b1) begin n++; @(posedge pclk); end
    endtask
    task arm(input int m, input int dv);
        apb(1, SEC, s); apb(1, PRI, p);
        apb(1, MDE, {16'h0, dv[7:0], 6'h0, m[1:0]});
        apb(1, CTL, 32'h1);
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, PRI, 0); check("primary reset", rd, 32'hFF);
        apb(0, 14'h0, 0); check("unmapped err", err, 1); check("unmapped data", rd, 0);
        for (int m = 1; m < 4; m++) begin
            d = m - 1; s = $random(seed) & 32'h1F; p = $random(seed) & 32'h1F;
            arm(m, d); hi_len; check("second phase", n, span(d, s));
            apb(1, CTL, 32'h4);
            apb(1, SEC, 32'h05); apb(1, CTL, 32'h1);
            // Stop preset wins; the new secondary waits for a primary write
            hi_len; check("stop preset", n, span(d, 255));
            apb(1, CTL, 32'h4);
        end
        // Primary differs from secondary, so a read of the reload value would show
        s = 3; p = 9; arm(1, 255);
        while (wave_out !== 1'b1) @(posedge pclk);
        // One prescaler wrap into the secondary phase the count is one below its load
        repeat (300) @(posedge pclk);
        apb(0, PRI, 0); check("live count", rd, s - 1);
        apb(1, CTL, 32'h4);
        p = 32'hFF & $random(seed) | 32'h1; d = 2; arm(0, d);
        while (underflow_pulse !== 1'b1) @(posedge pclk);
        @(posedge pclk) n = 1;
        while (underflow_pulse !== 1'b1) begin n++; @(posedge pclk); end
        check("timer reload", n, span(d, p)); check("timer wave", wave_out, 0);
        apb(1, CTL, 32'h4); apb(0, PRI, 0); check("stopped count", rd, p);
        complete_run;
    end
    initial begin
        #(20 * 60000);
        fail_count++;
        complete_run;
    end
endmodule
bind tpsp_timer tpsp_timer_monitor tpsp_timer_monitor_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .underflow_pulse, .wave_out, .running);
